// ===== logic/aqrf_formatter.sv
// Asynchronous quadlet receive formatter: packet fields to buffer quadlets
`timescale 1ns/100ps
`default_nettype none

module aqrf_formatter (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Configuration
  input wire logic token_insert_enable_i,
  // Received packet from link receive path
  input wire logic pkt_valid_i,
  output logic pkt_ready_o,
  input wire logic [9:0] pkt_dest_bus_i,
  input wire logic [5:0] pkt_dest_node_i,
  input wire logic [5:0] pkt_tlabel_i,
  input wire logic [1:0] pkt_retry_code_i,
  input wire logic [3:0] pkt_tcode_i,
  input wire logic [3:0] pkt_priority_i,
  input wire logic [15:0] pkt_src_id_i,
  input wire logic [15:0] pkt_offset_high_i,
  input wire logic [31:0] pkt_offset_low_i,
  input wire logic [31:0] pkt_data_i,
  // Packet status for the token
  input wire logic [4:0] pkt_acknowledge_code_i,
  input wire logic [1:0] pkt_speed_i,
  input wire logic pkt_self_id_i,
  input wire logic pkt_phy_i,
  // Receive data buffer write side
  output logic buf_valid_o,
  input wire logic buf_ready_i,
  output logic [31:0] buf_data_o,
  output logic buf_first_o,
  output logic buf_last_o
);

  // ----------------------------------------
  // Stored word layout
  // ----------------------------------------
  // Token word, only when insert enable is set:
  // [31:30] reserved, zero
  // [29:16] stored size in quadlets, token included
  // [15] self-ID flag
  // [14] PHY packet flag
  // [13] reserved, zero
  // [12:8] acknowledge code
  // [7:6] filler byte count, always zero here
  // [5:4] speed code, never the undefined code
  // [3:0] reserved, zero
  // Destination word:
  // [31:16] bus number then node number
  // [15:10] transaction label
  // [9:8] retry code
  // [7:4] transaction code
  // [3:0] priority
  // Source word: source ID over high offset
  // Low offset word, then data for quadlet write request or quadlet read response
  // Handshake:
  // A packet is taken when valid meets ready
  // Each word stands until the buffer takes it
  // Ready returns the cycle after the last word is taken
  // Packet inputs are not looked at while busy
  // Reset drops any packet still in flight
  // No word is stored twice and none is skipped

  // ----------------------------------------
  // Captured packet
  // ----------------------------------------
  logic [15:0] dest_id_q;        // Destination bus and node
  logic [15:0] dest_id_d;
  logic [15:0] pkt_info_q;       // Label, retry, tcode, priority
  logic [15:0] pkt_info_d;
  logic [31:0] src_word_q;       // Source ID with high offset
  logic [31:0] src_word_d;
  logic [31:0] off_low_q;        // Low offset
  logic [31:0] data_q;           // Data quadlet
  logic has_data_q;              // Packet carries a data quadlet
  logic has_data_d;

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  aqrf_pkg::aqrf_state_t state_q;  // Word now held at the output
  aqrf_pkg::aqrf_state_t state_d;
  logic [31:0] word_q;           // Buffer word
  logic [31:0] word_d;
  logic valid_q;                 // Buffer word valid
  logic valid_d;
  logic first_q;                 // First word of packet
  logic first_d;
  logic last_q;                  // Last word of packet
  logic last_d;
  logic ready_q;                 // Accepting a new packet
  logic ready_d;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire accept = pkt_valid_i && ready_q;        // New packet taken
  wire drain = valid_q && buf_ready_i;         // Current word taken by buffer

  // Data quadlet present only for these transaction types
  wire tcode_has_data = (pkt_tcode_i == aqrf_pkg::TCODE_WR_QUAD_REQ) ||
                        (pkt_tcode_i == aqrf_pkg::TCODE_RD_QUAD_RSP);

  // Speed saturates so the undefined code never reaches the token
  wire [1:0] spd_code = (pkt_speed_i == 2'h3) ? aqrf_pkg::SPD_S400 : pkt_speed_i;

  // Total stored quadlets: header, optional data, optional token
  wire [13:0] pkt_size = aqrf_pkg::HDR_QUADLETS + {13'h0, tcode_has_data}
                         + {13'h0, token_insert_enable_i};

  // Packet control token, reserved bits left zero
  logic [31:0] token_word;
  always_comb begin
    token_word = 32'h0;
    token_word[aqrf_pkg::TOK_SIZE_LSB +: aqrf_pkg::TOK_SIZE_W] = pkt_size;
    token_word[aqrf_pkg::TOK_SELF_BIT] = pkt_self_id_i;
    token_word[aqrf_pkg::TOK_PHY_BIT] = pkt_phy_i;
    token_word[aqrf_pkg::TOK_ACK_LSB +: aqrf_pkg::TOK_ACK_W] = pkt_acknowledge_code_i;
    token_word[aqrf_pkg::TOK_PAD_LSB +: aqrf_pkg::TOK_PAD_W] = aqrf_pkg::PAD_BYTES;
    token_word[aqrf_pkg::TOK_SPD_LSB +: aqrf_pkg::TOK_SPD_W] = spd_code;
  end

  // Header fields assembled as received
  assign dest_id_d = {pkt_dest_bus_i, pkt_dest_node_i};
  assign pkt_info_d = {pkt_tlabel_i, pkt_retry_code_i, pkt_tcode_i, pkt_priority_i};
  assign src_word_d = {pkt_src_id_i, pkt_offset_high_i};
  assign has_data_d = tcode_has_data;

  // ----------------------------------------
  // Word sequencing
  // ----------------------------------------
  // Chooses the next word and its markers
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    valid_d = valid_q;
    first_d = first_q;
    last_d = last_q;
    ready_d = ready_q;
    if (accept) begin
      // Start with the token or directly with the header
      ready_d = 1'b0;
      valid_d = 1'b1;
      first_d = 1'b1;
      last_d = 1'b0;
      if (token_insert_enable_i) begin
        state_d = aqrf_pkg::ST_TOKEN;
        word_d = token_word;
      end else begin
        state_d = aqrf_pkg::ST_DEST;
        word_d = {dest_id_d, pkt_info_d};
      end
    end else if (drain) begin
      first_d = 1'b0;
      unique case (state_q)
        aqrf_pkg::ST_TOKEN: begin
          // Destination word follows the token
          state_d = aqrf_pkg::ST_DEST;
          word_d = {dest_id_q, pkt_info_q};
        end
        aqrf_pkg::ST_DEST: begin
          // Source and high offset
          state_d = aqrf_pkg::ST_SRC;
          word_d = src_word_q;
        end
        aqrf_pkg::ST_SRC: begin
          // Low offset closes the header
          state_d = aqrf_pkg::ST_OFFLO;
          word_d = off_low_q;
          last_d = !has_data_q;
        end
        aqrf_pkg::ST_OFFLO: begin
          if (has_data_q) begin
            // Trailing data quadlet
            state_d = aqrf_pkg::ST_DATA;
            word_d = data_q;
            last_d = 1'b1;
          end else begin
            // Packet done
            state_d = aqrf_pkg::ST_IDLE;
            valid_d = 1'b0;
            last_d = 1'b0;
            ready_d = 1'b1;
          end
        end
        aqrf_pkg::ST_DATA: begin
          // Packet done
          state_d = aqrf_pkg::ST_IDLE;
          valid_d = 1'b0;
          last_d = 1'b0;
          ready_d = 1'b1;
        end
        aqrf_pkg::ST_IDLE: begin
          // Nothing held
          valid_d = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Sequencing state, back to idle on reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= aqrf_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Buffer word, cleared on reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      word_q <= aqrf_pkg::WORD_RST;
    end else begin
      word_q <= word_d;
    end
  end

  // Word valid and packet ready; idle means ready
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      valid_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      valid_q <= valid_d;
      ready_q <= ready_d;
    end
  end

  // First and last word markers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      first_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      first_q <= first_d;
      last_q <= last_d;
    end
  end

  // Destination word fields, taken on accept
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dest_id_q <= 16'h0;
      pkt_info_q <= 16'h0;
    end else if (accept) begin
      dest_id_q <= dest_id_d;
      pkt_info_q <= pkt_info_d;
    end
  end

  // Source word and low offset, taken on accept
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      src_word_q <= 32'h0;
      off_low_q <= 32'h0;
    end else if (accept) begin
      src_word_q <= src_word_d;
      off_low_q <= pkt_offset_low_i;
    end
  end

  // Data quadlet and whether it goes out
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      data_q <= 32'h0;
      has_data_q <= 1'b0;
    end else if (accept) begin
      data_q <= pkt_data_i;
      has_data_q <= has_data_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pkt_ready_o = ready_q;
  assign buf_valid_o = valid_q;
  assign buf_data_o = word_q;
  assign buf_first_o = first_q;
  assign buf_last_o = last_q;

endmodule

`default_nettype wire

// ===== common/aqrf_pkg.sv
// Shared constants for the asynchronous quadlet receive formatter
package aqrf_pkg;

  // ----------------------------------------
  // Packet control token field positions
  // ----------------------------------------
  localparam int TOK_SIZE_LSB = 16;   // Data size field low bit
  localparam int TOK_SIZE_W = 14;     // Data size field width
  localparam int TOK_SELF_BIT = 15;   // Self-ID flag
  localparam int TOK_PHY_BIT = 14;    // PHY packet flag
  localparam int TOK_ACK_LSB = 8;     // Acknowledge code low bit
  localparam int TOK_ACK_W = 5;       // Acknowledge code width
  localparam int TOK_PAD_LSB = 6;     // Padding count low bit
  localparam int TOK_PAD_W = 2;       // Padding count width
  localparam int TOK_SPD_LSB = 4;     // Speed code low bit
  localparam int TOK_SPD_W = 2;       // Speed code width

  // ----------------------------------------
  // Header field widths
  // ----------------------------------------
  localparam int BUS_W = 10;          // Bus number width
  localparam int NODE_W = 6;          // Node number width
  localparam int TLABEL_W = 6;        // Transaction label width
  localparam int RETRY_W = 2;         // Retry code width
  localparam int TCODE_W = 4;         // Transaction code width
  localparam int PRI_W = 4;           // Priority width
  localparam int OFFHI_W = 16;        // High offset width
  localparam int OFFLO_W = 32;        // Low offset width

  // ----------------------------------------
  // Speed codes
  // ----------------------------------------
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;

  // ----------------------------------------
  // Transaction codes that carry a data quadlet
  // ----------------------------------------
  localparam logic [3:0] TCODE_WR_QUAD_REQ = 4'h0;
  localparam logic [3:0] TCODE_RD_QUAD_RSP = 4'h6;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam logic [13:0] HDR_QUADLETS = 14'h3;   // Header quadlets stored
  localparam logic [1:0] PAD_BYTES = 2'h0;        // Quadlet packets need no filler
  localparam logic [31:0] WORD_RST = 32'h0;       // Output word after reset

  // Output word selector
  typedef enum {
    ST_IDLE,
    ST_TOKEN,
    ST_DEST,
    ST_SRC,
    ST_OFFLO,
    ST_DATA
  } aqrf_state_t;

endpackage

// ===== verification/aqrf_formatter_assertions.sv
// Port-level properties of the receive formatter
`timescale 1ns/100ps
`default_nettype none
module aqrf_formatter_assertions (
  // Clock, reset, control
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic token_insert_enable_i,
  // Packet side
  input wire logic pkt_valid_i,
  input wire logic pkt_ready_o,
  input wire logic [9:0] pkt_dest_bus_i,
  input wire logic [5:0] pkt_dest_node_i,
  input wire logic [5:0] pkt_tlabel_i,
  input wire logic [1:0] pkt_retry_code_i,
  input wire logic [3:0] pkt_tcode_i,
  input wire logic [3:0] pkt_priority_i,
  input wire logic [4:0] pkt_acknowledge_code_i,
  input wire logic pkt_self_id_i,
  input wire logic pkt_phy_i,
  // Buffer side
  input wire logic buf_valid_o,
  input wire logic buf_ready_i,
  input wire logic [31:0] buf_data_o,
  input wire logic buf_first_o,
  input wire logic buf_last_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Packet taken, packet taken with token, last word drained
  sequence s_take; pkt_valid_i && pkt_ready_o; endsequence
  sequence s_tok; s_take ##0 token_insert_enable_i; endsequence
  sequence s_drain; buf_valid_o && buf_ready_i && buf_last_o; endsequence
  take_answer_a: assert property (s_take |=> !pkt_ready_o && buf_valid_o && buf_first_o)
    else $error("no first word after take");
  tok_flags_a: assert property (s_tok |=> buf_data_o[15:8] ==
    {$past(pkt_self_id_i), $past(pkt_phy_i), 1'b0, $past(pkt_acknowledge_code_i)})
    else $error("token flags wrong");
  tok_size_a: assert property (s_tok |=> buf_data_o[29:16] ==
    (($past(pkt_tcode_i) == 4'h0 || $past(pkt_tcode_i) == 4'h6) ? 14'h5 : 14'h4))
    else $error("token size wrong");
  tok_resv_a: assert property (s_tok |=> buf_data_o[31:30] == 2'h0 && !buf_data_o[13] &&
    buf_data_o[7:6] == 2'h0 && buf_data_o[5:4] != 2'h3 && buf_data_o[3:0] == 4'h0)
    else $error("token fixed bits wrong");
  dest_word_a: assert property (s_take ##0 !token_insert_enable_i |=> buf_data_o ==
    {$past(pkt_dest_bus_i), $past(pkt_dest_node_i), $past(pkt_tlabel_i),
    $past(pkt_retry_code_i), $past(pkt_tcode_i), $past(pkt_priority_i)})
    else $error("header word wrong");
  word_hold_a: assert property (buf_valid_o && !buf_ready_i |=>
    buf_valid_o && $stable(buf_data_o) && $stable(buf_last_o)) else $error("word not held");
  drain_ready_a: assert property (s_drain |=> pkt_ready_o && !buf_valid_o)
    else $error("not idle after last word");
  busy_hold_a: assert property (!pkt_ready_o && !(buf_valid_o && buf_ready_i && buf_last_o)
    |=> !pkt_ready_o) else $error("ready early");
endmodule
bind aqrf_formatter aqrf_formatter_assertions u_chk (.*);
`default_nettype wire

// ===== verification/aqrf_buf_reader.sv
// Application-side reader of the receive buffer, with optional stalls
`timescale 1ns/100ps
`default_nettype none
module aqrf_buf_reader (
  // Clock and stall mode
  input wire logic sys_clk_i,
  input wire logic stall_i,
  // Buffer write side of the formatter
  input wire logic buf_valid_i,
  input wire logic [31:0] buf_data_i,
  input wire logic buf_first_i,
  input wire logic buf_last_i,
  output logic buf_ready_o
);
  logic [31:0] got_q[$]; // Words taken, in order
  logic [1:0] flg_q[$]; // First and last markers of each word taken
  int cyc_q = 0; // Cycle count for the stall pattern
  initial buf_ready_o = 1'b0;
  // Take a word on each handshake edge, then move ready just after
  always @(posedge sys_clk_i) begin
    if (buf_valid_i && buf_ready_o) begin
      got_q.push_back(buf_data_i);
      flg_q.push_back({buf_first_i, buf_last_i});
    end
    cyc_q++;
    #1 buf_ready_o = !stall_i || cyc_q[0];
  end
endmodule
`default_nettype wire

// ===== verification/aqrf_formatter_tb.sv
// Self-checking bench for the receive formatter
`timescale 1ns/100ps
`default_nettype none
module aqrf_formatter_tb;
  // Design signals, named as the ports
  logic sys_clk_i = 1'b0, reset_i = 1'b1, token_insert_enable_i = 1'b0, pkt_valid_i = 1'b0;
  logic pkt_self_id_i = 1'b0, pkt_phy_i = 1'b0, stall = 1'b0;
  logic [9:0] pkt_dest_bus_i = 10'h0;
  logic [5:0] pkt_dest_node_i = 6'h0, pkt_tlabel_i = 6'h0;
  logic [1:0] pkt_retry_code_i = 2'h0, pkt_speed_i = 2'h0;
  logic [3:0] pkt_tcode_i = 4'h0, pkt_priority_i = 4'h0;
  logic [15:0] pkt_src_id_i = 16'h0, pkt_offset_high_i = 16'h0;
  logic [31:0] pkt_offset_low_i = 32'h0, pkt_data_i = 32'h0, buf_data_o;
  logic [4:0] pkt_acknowledge_code_i = 5'h0;
  logic pkt_ready_o, buf_valid_o, buf_first_o, buf_last_o, buf_ready_i;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  // Rows: token enable, tcode, speed in, speed expected
  typedef struct packed {logic en; logic [3:0] tc; logic [1:0] spd; logic [1:0] xs;} aqrf_row_t;
  localparam aqrf_row_t ROWS [8] = '{'{1'b1, 4'h0, 2'h0, 2'h0}, '{1'b1, 4'h1, 2'h1, 2'h1},
    '{1'b1, 4'h4, 2'h2, 2'h2}, '{1'b1, 4'h6, 2'h3, 2'h2}, '{1'b0, 4'h0, 2'h1, 2'h1},
    '{1'b0, 4'hB, 2'h0, 2'h0}, '{1'b1, 4'hB, 2'h2, 2'h2}, '{1'b0, 4'h6, 2'h3, 2'h2}};
  aqrf_formatter dut (.*);
  aqrf_buf_reader rdr (.sys_clk_i, .stall_i(stall), .buf_valid_i(buf_valid_o),
    .buf_data_i(buf_data_o), .buf_first_i(buf_first_o), .buf_last_i(buf_last_o),
    .buf_ready_o(buf_ready_i));
  always #4 sys_clk_i = ~sys_clk_i;
  // Hang guard, far above the expected run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Offer packet i; valid held through refused edges until taken
  task automatic send(input int i);
    @(posedge sys_clk_i) #1;
    {token_insert_enable_i, pkt_tcode_i, pkt_speed_i} = {ROWS[i].en, ROWS[i].tc, ROWS[i].spd};
    {pkt_dest_bus_i, pkt_dest_node_i} = {10'(i * 37), 6'(i + 1)};
    {pkt_tlabel_i, pkt_retry_code_i} = {6'(63 - i), 2'(i)};
    {pkt_self_id_i, pkt_phy_i, pkt_acknowledge_code_i} = {i[0], i[1], 5'(i * 3)};
    pkt_src_id_i = 16'(4096 + i);
    pkt_offset_high_i = {4'(i), 12'h0};
    pkt_offset_low_i = {30'(i * 5), 2'h0};
    pkt_data_i = 32'hA5000000 + 32'(i);
    pkt_valid_i = 1'b1;
    while (pkt_ready_o !== 1'b1) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1;
    pkt_valid_i = 1'b0;
  endtask
  // Expected words from the held inputs, then compare with what was read
  task automatic expect_pkt(input int i);
    logic [31:0] w[$];
    logic [1:0] sp;
    sp = ROWS[i].xs;
    w = '{{pkt_dest_bus_i, pkt_dest_node_i, pkt_tlabel_i, pkt_retry_code_i, pkt_tcode_i,
      pkt_priority_i}, {pkt_src_id_i, pkt_offset_high_i}, pkt_offset_low_i};
    if (pkt_tcode_i == 4'h0 || pkt_tcode_i == 4'h6) w.push_back(pkt_data_i);
    if (token_insert_enable_i) w.push_front({2'h0, 14'(w.size() + 1), pkt_self_id_i, pkt_phy_i,
      1'b0, pkt_acknowledge_code_i, 2'h0, sp, 4'h0});
    repeat (40) if (rdr.got_q.size() < w.size()) @(posedge sys_clk_i) #1;
    repeat (2) @(posedge sys_clk_i) #1;
    chk(32'(w.size()), 32'(rdr.got_q.size()));
    foreach (w[k]) chk(w[k], rdr.got_q[k]);
    foreach (w[k]) chk({30'h0, k == 0, k == w.size() - 1}, {30'h0, rdr.flg_q[k]});
    rdr.got_q.delete();
    rdr.flg_q.delete();
  endtask
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Table loop, then a reset in mid-packet and a packet after it
  initial begin
    repeat (3) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      stall = i[0];
      send(i);
      expect_pkt(i);
    end
    send(3);
    @(posedge sys_clk_i) #1;
    reset_i = 1'b1;
    @(posedge sys_clk_i) #1;
    chk(32'h8, {28'h0, pkt_ready_o, buf_valid_o, buf_first_o, buf_last_o});
    chk(32'h0, buf_data_o);
    reset_i = 1'b0;
    rdr.got_q.delete();
    rdr.flg_q.delete();
    send(6);
    expect_pkt(6);
    report_and_stop();
  end
endmodule
`default_nettype wire
